// File: design/i2c_target.sv
// Byte-wide configuration bus target with a register pointer.
// Assumes scl_i and sda_i are synchronous to mclk and far slower than it.
`timescale 1ns/1ps
module i2c_target
  import redriver_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe,
  output logic            wr_stb,
  output logic [7:0]      wr_data,
  output logic [7:0]      ptr,
  input  wire logic [7:0] rd_data
);

  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ADDR_ACK, T_WR, T_WR_ACK, T_RD, T_RD_ACK} tgt_e;

  tgt_e       st_reg;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic       rw_reg;
  logic       first_reg;
  logic       mack_reg;

  // Line events from the previous sample
  wire start_ev = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_ev  = scl_i & scl_q & ~sda_q & sda_i;
  wire rise_ev  = scl_i & ~scl_q;
  wire fall_ev  = ~scl_i & scl_q;

  assign wr_data = sh_reg;

  // Previous line levels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Protocol sequencer; a start or stop always resynchronises, even mid-byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg    <= T_IDLE;
      sh_reg    <= 8'h00;
      cnt_reg   <= 4'h0;
      rw_reg    <= 1'b0;
      first_reg <= 1'b0;
      mack_reg  <= 1'b0;
      sda_oe    <= 1'b0;
      wr_stb    <= 1'b0;
      ptr       <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (!enable || stop_ev) begin
        st_reg <= T_IDLE;
        sda_oe <= 1'b0;
      end else if (start_ev) begin
        st_reg  <= T_ADDR;
        cnt_reg <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (rise_ev) begin
        if (st_reg == T_ADDR || st_reg == T_WR) begin
          sh_reg  <= {sh_reg[6:0], sda_i};
          cnt_reg <= cnt_reg + 4'h1;
        end else if (st_reg == T_RD_ACK) begin
          mack_reg <= ~sda_i;
        end
      end else if (fall_ev) begin
        case (st_reg)
          T_ADDR: begin
            if (cnt_reg == 4'h8) begin
              if (sh_reg[7:1] == I2C_ADDR) begin
                st_reg <= T_ADDR_ACK;
                rw_reg <= sh_reg[0];
                sda_oe <= 1'b1;
              end else begin
                st_reg <= T_IDLE;
              end
            end
          end
          T_ADDR_ACK: begin
            cnt_reg <= 4'h0;
            if (rw_reg) begin
              st_reg <= T_RD;
              sh_reg <= rd_data;
              sda_oe <= ~rd_data[7];
            end else begin
              st_reg    <= T_WR;
              first_reg <= 1'b1;
              sda_oe    <= 1'b0;
            end
          end
          T_WR: begin
            if (cnt_reg == 4'h8) begin
              st_reg <= T_WR_ACK;
              sda_oe <= 1'b1;
              if (first_reg) begin
                ptr <= sh_reg;
              end else begin
                wr_stb <= 1'b1;
              end
            end
          end
          T_WR_ACK: begin
            st_reg  <= T_WR;
            sda_oe  <= 1'b0;
            cnt_reg <= 4'h0;
            if (!first_reg) begin
              ptr <= ptr + 8'h01; // Auto-increment after each data byte
            end
            first_reg <= 1'b0;
          end
          T_RD: begin
            if (cnt_reg == 4'h7) begin
              st_reg <= T_RD_ACK;
              sda_oe <= 1'b0;
              ptr    <= ptr + 8'h01;
            end else begin
              sh_reg  <= {sh_reg[6:0], 1'b0};
              sda_oe  <= ~sh_reg[6];
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          T_RD_ACK: begin
            cnt_reg <= 4'h0;
            if (mack_reg) begin
              st_reg <= T_RD;
              sh_reg <= rd_data;
              sda_oe <= ~rd_data[7];
            end else begin
              st_reg <= T_IDLE; // Host NACK ends the read
            end
          end
          default: st_reg <= T_IDLE;
        endcase
      end
    end
  end

endmodule

// File: design/usb_redriver_config_control.sv
// Configuration and mode control of a USB 2.0 high-speed redriver.
// Assumes speed detection, strap comparators and bus pins arrive synchronous to mclk.
`timescale 1ns/1ps
module usb_redriver_config_control
  import redriver_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       active_low_chip_disable,
  input  wire logic [1:0] ac_gain_strap,
  input  wire logic [1:0] dc_gain_strap,
  input  wire logic       speed_ls_det,
  input  wire logic       speed_fs_det,
  input  wire logic       speed_hs_det,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            connection_detect_out,
  output logic            comp_enable,
  output logic [2:0]      comp_ac_level,
  output logic [2:0]      comp_dc_level,
  output logic            i2c_mode
);

  // AC strap level (0..3) to field code
  function automatic logic [2:0] ac_code(input logic [1:0] lvl);
    case (lvl)
      2'h0:    ac_code = AC_LVL0;
      2'h1:    ac_code = AC_LVL1;
      2'h2:    ac_code = AC_LVL2;
      default: ac_code = AC_LVL3;
    endcase
  endfunction

  // Three-level DC strap to field code; an undefined strap reads as mid
  function automatic logic [2:0] dc_code(input logic [1:0] lvl);
    case (lvl)
      DC_STRAP_LOW:  dc_code = DC_40MV;
      DC_STRAP_HIGH: dc_code = DC_80MV;
      default:       dc_code = DC_60MV;
    endcase
  endfunction

  cond_state_e      state_reg;
  logic [CNT_W-1:0] dis_cnt;
  logic [CNT_W-1:0] samp_cnt;
  logic [2:0]       ac_level_reg;
  logic [2:0]       dc_level_reg;
  logic             hold_reg;
  logic             bus_wr;
  logic [7:0]       bus_wdata;
  logic [7:0]       bus_ptr;
  logic [7:0]       rd_data;

  wire samp_done  = (samp_cnt == CNT_W'(SAMPLE_CYC - 1));
  wire dis_expire = (dis_cnt == CNT_W'(DIS_MIN_CYC - 1)) & ~active_low_chip_disable;
  wire lines_high = scl_i & sda_i;
  wire link_up    = speed_ls_det | speed_fs_det | speed_hs_det;

  // The pin is open drain, so only the enable ever changes
  assign sda_o = 1'b0;

  // Low-time filter on the disable pin; short glitches never reach shutdown
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dis_cnt <= '0;
    end else if (active_low_chip_disable) begin
      dis_cnt <= '0;
    end else if (!dis_expire) begin
      dis_cnt <= dis_cnt + CNT_W'(1);
    end
  end

  // Settle counter after power-up or after the disable pin is released
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt <= '0;
    end else if (state_reg != ST_SAMPLE) begin
      samp_cnt <= '0;
    end else if (!samp_done) begin
      samp_cnt <= samp_cnt + CNT_W'(1);
    end
  end

  // Conditioning state machine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_SAMPLE;
    end else if (dis_expire) begin
      state_reg <= ST_SHUT;
    end else begin
      case (state_reg)
        ST_SHUT: begin
          if (active_low_chip_disable) begin
            state_reg <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (samp_done) begin
            state_reg <= lines_high ? ST_CONFIG : ST_RUN;
          end
        end
        ST_CONFIG: begin
          if (!hold_reg) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (hold_reg) begin
            state_reg <= ST_CONFIG;
          end
        end
        default: state_reg <= ST_SAMPLE;
      endcase
    end
  end

  // Bus mode is decided once per release, from both lines sampled high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      i2c_mode <= 1'b0;
    end else if (state_reg == ST_SAMPLE && samp_done) begin
      i2c_mode <= lines_high;
    end
  end

  // Gain fields: straps caught only at the end of the settle window, then bus-writable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ac_level_reg <= AC_LVL0;
      dc_level_reg <= DC_60MV;
    end else if (state_reg == ST_SAMPLE) begin
      if (samp_done) begin
        ac_level_reg <= ac_code(ac_gain_strap);
        dc_level_reg <= dc_code(dc_gain_strap);
      end
    end else if (bus_wr) begin
      if (bus_ptr == OFS_AC_GAIN) begin
        ac_level_reg <= bus_wdata[AC_LSB+:3];
      end
      if (bus_ptr == OFS_DC_GAIN) begin
        dc_level_reg <= bus_wdata[DC_LSB+:3];
      end
    end
  end

  // Hold bit: set on every release; only a bus write clears it in bus mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= HOLD_RST;
    end else if (state_reg == ST_SHUT) begin
      hold_reg <= HOLD_RST;
    end else if (state_reg == ST_SAMPLE) begin
      hold_reg <= samp_done ? lines_high : HOLD_RST;
    end else if (bus_wr && bus_ptr == OFS_HOLD) begin
      hold_reg <= bus_wdata[HOLD_BIT];
    end
  end

  // Applied gains track the fields while stopped and freeze once running.
  // Strap mode enters RUN on the very edge that latches the straps, so the
  // strap codes are passed straight through there, or stale gains would freeze.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      comp_ac_level <= AC_LVL0;
      comp_dc_level <= DC_60MV;
    end else if (state_reg == ST_SAMPLE && samp_done) begin
      comp_ac_level <= ac_code(ac_gain_strap);
      comp_dc_level <= dc_code(dc_gain_strap);
    end else if (state_reg != ST_RUN) begin
      comp_ac_level <= ac_level_reg;
      comp_dc_level <= dc_level_reg;
    end
  end

  // Link status outputs; nothing reported outside normal running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      connection_detect_out <= 1'b0;
      comp_enable           <= 1'b0;
    end else begin
      connection_detect_out <= (state_reg == ST_RUN) & link_up;
      comp_enable           <= (state_reg == ST_RUN) & speed_hs_det;
    end
  end

  // Read mux; reserved fields and unmapped offsets read zero
  always_comb begin
    rd_data = 8'h00;
    case (bus_ptr)
      OFS_AC_GAIN: rd_data[AC_LSB+:3] = ac_level_reg;
      OFS_HOLD:    rd_data[HOLD_BIT]  = hold_reg;
      OFS_DC_GAIN: rd_data[DC_LSB+:3] = dc_level_reg;
      default:     rd_data = 8'h00;
    endcase
  end

  // Target runs only in bus mode and only after the settle window
  i2c_target u_target (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .enable  (i2c_mode && state_reg != ST_SHUT && state_reg != ST_SAMPLE),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sda_oe  (sda_oe),
    .wr_stb  (bus_wr),
    .wr_data (bus_wdata),
    .ptr     (bus_ptr),
    .rd_data (rd_data)
  );

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  wire is_shut = (state_reg == ST_SHUT);

  shut_no_status_a: assert property (is_shut |=> !connection_detect_out && !comp_enable)
    else $error("status shown during shutdown");
  hs_comp_on_a: assert property (state_reg == ST_RUN && speed_hs_det && !dis_expire
      |=> comp_enable && connection_detect_out)
    else $error("high speed without compensation");
  fsls_comp_off_a: assert property (state_reg == ST_RUN && !speed_hs_det
      && (speed_ls_det || speed_fs_det) |=> !comp_enable && connection_detect_out)
    else $error("low or full speed handled wrongly");
  filter_width_a: assert property ($rose(is_shut) |-> $past(dis_cnt) == CNT_W'(DIS_MIN_CYC - 1))
    else $error("shutdown entered before minimum low time");
  hold_auto_clr_a: assert property (state_reg == ST_SAMPLE && samp_done && !lines_high
      && !dis_expire |=> !hold_reg && state_reg == ST_RUN && !i2c_mode)
    else $error("hold not cleared in strap mode");
  hold_bus_keep_a: assert property (state_reg == ST_SAMPLE && samp_done && lines_high
      && !dis_expire |=> hold_reg && i2c_mode ##1 hold_reg)
    else $error("hold not kept in bus mode");
  strap_latch_a: assert property (state_reg == ST_SAMPLE && samp_done
      |=> ac_level_reg == ac_code($past(ac_gain_strap))
       && dc_level_reg == dc_code($past(dc_gain_strap)))
    else $error("strap not loaded into gain fields");
  apply_gain_a: assert property (state_reg == ST_CONFIG && !hold_reg
      |=> comp_ac_level == $past(ac_level_reg) && comp_dc_level == $past(dc_level_reg))
    else $error("gains not applied on leaving configuration");
  run_hold_stop_a: assert property (state_reg == ST_RUN && hold_reg && !dis_expire
      |=> state_reg == ST_CONFIG)
    else $error("hold bit did not stop the machine");
  strap_apply_a: assert property (state_reg == ST_SAMPLE && samp_done && !lines_high
      && !dis_expire |=> comp_ac_level == ac_code($past(ac_gain_strap))
       && comp_dc_level == dc_code($past(dc_gain_strap)))
    else $error("strap gains not applied when running");

  hs_run_c: cover property (state_reg == ST_RUN && comp_enable);
  bus_cfg_c: cover property (state_reg == ST_CONFIG ##[1:1000] state_reg == ST_RUN);
  shutdown_c: cover property ($rose(is_shut));
  bus_write_c: cover property (bus_wr && bus_ptr == OFS_HOLD);

endmodule

// File: pkg/redriver_pkg.sv
// Shared constants for the USB 2.0 redriver configuration and mode control.
// Assumes a single 125 MHz clock; all pin inputs are synchronous to it.
package redriver_pkg;

  // Clock rate and derived timing
  localparam int CLK_MHZ      = 125;
  localparam int DIS_MIN_US   = 20;    // Least low time of the disable pin, in us
  localparam int DIS_MIN_CYC  = DIS_MIN_US * CLK_MHZ;
  localparam int SAMPLE_NS    = 1000;  // Settle time before straps and bus lines are sampled
  localparam int SAMPLE_CYC   = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W        = 12;

  // Target address on the configuration bus
  localparam logic [6:0] I2C_ADDR = 7'h2C;

  // Register offsets
  localparam logic [7:0] OFS_AC_GAIN = 8'h01;
  localparam logic [7:0] OFS_HOLD    = 8'h03;
  localparam logic [7:0] OFS_DC_GAIN = 8'h0E;

  // Field positions
  localparam int AC_LSB   = 4;
  localparam int DC_LSB   = 0;
  localparam int HOLD_BIT = 0;

  // Reset value of the hold bit
  localparam logic HOLD_RST = 1'b1;

  // Gain field encodings
  localparam logic [2:0] AC_LVL0 = 3'h0;
  localparam logic [2:0] AC_LVL1 = 3'h1;
  localparam logic [2:0] AC_LVL2 = 3'h3;
  localparam logic [2:0] AC_LVL3 = 3'h7;
  localparam logic [2:0] DC_40MV = 3'h3;
  localparam logic [2:0] DC_60MV = 3'h5;
  localparam logic [2:0] DC_80MV = 3'h7;

  // Three-level DC strap as delivered by the pin comparator
  localparam logic [1:0] DC_STRAP_LOW  = 2'h0;
  localparam logic [1:0] DC_STRAP_MID  = 2'h1;
  localparam logic [1:0] DC_STRAP_HIGH = 2'h2;

  // Conditioning state machine
  typedef enum logic [1:0] {ST_SAMPLE, ST_SHUT, ST_CONFIG, ST_RUN} cond_state_e;

endpackage

// File: tb/i2c_host_model.sv
// Behavioural configuration-bus host that drives open-drain SCL and SDA.
// Assumes the bench resolves SDA with a pull-up and feeds the level back on sda_line.
`timescale 1ns/1ps
module i2c_host_model
  import redriver_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl_out,
  output logic      sda_pull
);
  // Idle bus: both lines released, so the pull-ups hold them high
  initial begin
    scl_out  = 1'b1;
    sda_pull = 1'b0;
  end

  // Eight mclk per SCL phase, twice the least that the target needs
  task automatic half;
    repeat (8) @(negedge mclk);
  endtask

  // START, also a repeated START when entered with SCL low
  task automatic start;
    sda_pull = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl_out = 1'b0;
  endtask

  task automatic stop;
    repeat (2) @(negedge mclk);
    sda_pull = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask

  // One byte MSB first plus the ninth bit; SDA moves only well after SCL falls
  task automatic xfer(input logic [7:0] tx, input logic host_ack,
                      output logic [7:0] rx, output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      repeat (2) @(negedge mclk);
      sda_pull = ~tx[i];
      half();
      scl_out = 1'b1;
      half();
      rx[i]   = sda_line;
      scl_out = 1'b0;
    end
    repeat (2) @(negedge mclk);
    sda_pull = host_ack;
    half();
    scl_out = 1'b1;
    half();
    ack_seen = sda_line;
    scl_out  = 1'b0;
  endtask

  // Pointer byte then one data byte; ok is low if any byte went unacknowledged
  task automatic wr_reg(input logic [6:0] adr, input logic [7:0] ofs,
                        input logic [7:0] dat, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2;
    start();
    xfer({adr, 1'b0}, 1'b0, rx, a0);
    xfer(ofs, 1'b0, rx, a1);
    xfer(dat, 1'b0, rx, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask

  // Set the pointer, repeated START, read one byte and end it with a NACK
  task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] dat, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, nk;
    start();
    xfer({I2C_ADDR, 1'b0}, 1'b0, rx, a0);
    xfer(ofs, 1'b0, rx, a1);
    start();
    xfer({I2C_ADDR, 1'b1}, 1'b0, rx, a2);
    xfer(8'hFF, 1'b0, dat, nk);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
endmodule

// File: tb/usb_redriver_config_control_tb.sv
// Self-checking bench for the redriver configuration and mode control.
// Assumes the host model above and inputs driven on the falling edge of mclk.
`timescale 1ns/1ps
module usb_redriver_config_control_tb
  import redriver_pkg::*;
;
  logic       mclk, rst_n, active_low_chip_disable, scl_gate, sda_gate;
  logic       speed_ls_det, speed_fs_det, speed_hs_det;
  logic [1:0] ac_gain_strap, dc_gain_strap;
  logic       host_scl, host_sda_pull, scl_i, sda_line, sda_o, sda_oe;
  logic       connection_detect_out, comp_enable, i2c_mode;
  logic [2:0] comp_ac_level, comp_dc_level;
  logic [2:0] ac_tab [4];
  logic [2:0] dc_tab [3];
  int         num_errors, check_count;

  // Open-drain lines with pull-ups; the gates let the bench hold a line low
  assign scl_i    = host_scl & scl_gate;
  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~host_sda_pull & sda_gate;

  i2c_host_model host (.mclk(mclk), .sda_line(sda_line), .scl_out(host_scl),
                       .sda_pull(host_sda_pull));

  usb_redriver_config_control uut (
    .mclk(mclk), .rst_n(rst_n), .active_low_chip_disable(active_low_chip_disable),
    .ac_gain_strap(ac_gain_strap), .dc_gain_strap(dc_gain_strap),
    .speed_ls_det(speed_ls_det), .speed_fs_det(speed_fs_det), .speed_hs_det(speed_hs_det),
    .scl_i(scl_i), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .connection_detect_out(connection_detect_out), .comp_enable(comp_enable),
    .comp_ac_level(comp_ac_level), .comp_dc_level(comp_dc_level), .i2c_mode(i2c_mode));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Sampling window after release is 125 cycles; leave margin for the state change
  task automatic settle;
    repeat (140) @(negedge mclk);
  endtask

  // Full disable pulse with a look at the outputs while shut down
  task automatic dis_cycle;
    active_low_chip_disable = 1'b0;
    repeat (2520) @(negedge mclk);
    check("cd_shut", 8'h00, {7'h0, connection_detect_out});
    check("comp_shut", 8'h00, {7'h0, comp_enable});
    repeat (80) @(negedge mclk);
    active_low_chip_disable = 1'b1;
    settle();
  endtask

  // Bus mode after power-up: hold set, registers loaded from the straps
  task automatic t_bus_mode;
    logic [7:0] d;
    logic       ok;
    check("i2c_mode", 8'h01, {7'h0, i2c_mode});
    check("cd_config", 8'h00, {7'h0, connection_detect_out});
    host.rd_reg(OFS_HOLD, d, ok);
    check("hold_rst", 8'h01, d);
    host.rd_reg(OFS_AC_GAIN, d, ok);
    check("ac_rst", {1'b0, ac_tab[1], 4'h0}, d);
    host.rd_reg(OFS_DC_GAIN, d, ok);
    check("dc_rst", {5'h0, DC_40MV}, d);
    check("rd_ack", 8'h01, {7'h0, ok});
    host.wr_reg(7'h2D, OFS_HOLD, 8'h00, ok);
    check("wrong_adr", 8'h00, {7'h0, ok});
    check("hold_kept", 8'h00, {7'h0, comp_enable});
  endtask

  // Gain update by read-modify-write, then the hold toggle restarts the machine
  task automatic t_gain_write;
    logic [7:0] d;
    logic       ok;
    ac_gain_strap = 2'h3;
    dc_gain_strap = 2'h2;
    repeat (4) @(negedge mclk);
    check("strap_late", {5'h0, AC_LVL1}, {5'h0, comp_ac_level});
    host.rd_reg(OFS_AC_GAIN, d, ok);
    host.wr_reg(I2C_ADDR, OFS_AC_GAIN, (d & 8'h8F) | {1'b0, AC_LVL3, 4'h0}, ok);
    host.rd_reg(OFS_DC_GAIN, d, ok);
    host.wr_reg(I2C_ADDR, OFS_DC_GAIN, (d & 8'hF8) | {5'h0, DC_80MV}, ok);
    host.rd_reg(OFS_AC_GAIN, d, ok);
    check("ac_back", {1'b0, AC_LVL3, 4'h0}, d);
    host.wr_reg(I2C_ADDR, OFS_HOLD, 8'h00, ok);
    repeat (4) @(negedge mclk);
    check("comp_run", 8'h01, {7'h0, comp_enable});
    check("ac_applied", {5'h0, AC_LVL3}, {5'h0, comp_ac_level});
    check("dc_applied", {5'h0, DC_80MV}, {5'h0, comp_dc_level});
    host.rd_reg(OFS_HOLD, d, ok);
    check("hold_clr", 8'h00, d);
  endtask

  // A low pulse just short of the minimum must not reset the block
  task automatic t_short_pulse;
    active_low_chip_disable = 1'b0;
    repeat (2490) @(negedge mclk);
    active_low_chip_disable = 1'b1;
    repeat (4) @(negedge mclk);
    check("short_mode", 8'h01, {7'h0, i2c_mode});
    check("short_comp", 8'h01, {7'h0, comp_enable});
  endtask

  // Each speed indication: none, low, full, high
  task automatic t_speeds;
    for (int m = 0; m < 4; m++) begin
      {speed_hs_det, speed_fs_det, speed_ls_det} = (m == 0) ? 3'h0 : 3'h1 << (m - 1);
      repeat (3) @(negedge mclk);
      check("cd_speed", {7'h0, m != 0}, {7'h0, connection_detect_out});
      check("comp_speed", {7'h0, m == 3}, {7'h0, comp_enable});
    end
  endtask

  // Strap mode for every strap pair; one bus line is held low each time
  task automatic t_straps;
    for (int a = 0; a < 4; a++) begin
      for (int c = 0; c < 3; c++) begin
        ac_gain_strap = a[1:0];
        dc_gain_strap = c[1:0];
        scl_gate      = c[0];
        sda_gate      = ~c[0];
        speed_hs_det  = 1'b1;
        dis_cycle();
        check("strap_mode", 8'h00, {7'h0, i2c_mode});
        check("ac_strap", {5'h0, ac_tab[a]}, {5'h0, comp_ac_level});
        check("dc_strap", {5'h0, dc_tab[c]}, {5'h0, comp_dc_level});
        check("auto_run", 8'h01, {7'h0, comp_enable});
      end
    end
    t_speeds();
  endtask

  // Free-running 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Watchdog well beyond the expected run of about 340 us, under 100k cycles
  initial begin
    #600000;
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    ac_tab = '{AC_LVL0, AC_LVL1, AC_LVL2, AC_LVL3};
    dc_tab = '{DC_40MV, DC_60MV, DC_80MV};
    num_errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    active_low_chip_disable = 1'b1;
    ac_gain_strap = 2'h1;
    dc_gain_strap = 2'h0;
    {speed_ls_det, speed_fs_det, speed_hs_det} = 3'h1;
    scl_gate = 1'b1;
    sda_gate = 1'b1;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    settle();
    t_bus_mode();
    t_gain_write();
    t_short_pulse();
    t_straps();
    wrap_up();
  end
endmodule
